// *** rtl/adc_status.sv ***
// Indicator drive and fault code reporting for the analog input module.
//
// Behaviour
// RULE1 - The run indicator is lit while the module operates and dark else.
// RULE2 - The error indicator is steady for serious, blinks for minor faults.
// RULE3 - The conversion indicator blinks while converting, else is off.
// RULE4 - Serious faults report 1605, 1607, 1608 with conversion off.
// RULE5 - Minor faults report 1801, 1802, 1804 with conversion off.
// RULE6 - Over-range on channels 1 to 4 reports 1808 to 180B and blinks.
// RULE7 - Scale points give the digital ends mapped to the analog limits.
// RULE8 - The host downloads parameters only while its CPU is stopped.
// RULE9 - A disabled range check raises no over-range code for its channel.
// RULE10 - Serious faults take precedence over minor ones.
// RULE11 - All blinking uses one free-running divided enable.
`timescale 1ns/1ps
module adc_status (
    input wire logic MCLK_IN,
    input wire logic RESET_IN,
    input wire logic RUN_IN,
    input wire logic CONVERTING_IN,
    input wire logic [2:0] SERIOUS_IN,
    input wire logic [2:0] MINOR_IN,
    input wire logic [3:0] OVER_RANGE_IN,
    input wire logic [3:0] RANGE_CHECK_EN_IN,
    input wire logic HOST_CPU_RUN_IN,
    input wire logic PARAM_LOAD_IN,
    input wire logic [31:0] SCALE_HIGH_IN,
    input wire logic [31:0] SCALE_LOW_IN,
    output logic RUN_LED_OUT,
    output logic ERROR_LED_OUT,
    output logic CONV_LED_OUT,
    output logic [15:0] ERROR_CODE_OUT,
    output logic [31:0] SCALE_HIGH_POINT_OUT,
    output logic [31:0] SCALE_LOW_POINT_OUT
);
    typedef enum logic [1:0] {
        ST_OK = 2'h0,
        ST_MINOR = 2'h1,
        ST_SERIOUS = 2'h3
    } sev_e;

    localparam logic [24:0] BLINK_LAST =
        25'(status_pkg::BLINK_CYCLES - 1);

    logic [24:0] div_reg;
    logic blink_reg;
    sev_e sev_reg;
    sev_e sev_next;
    logic [15:0] code_reg;
    logic [15:0] code_next;
    status_pkg::leds_s leds_reg;
    status_pkg::leds_s leds_next;
    status_pkg::fault_s ser;
    status_pkg::fault_s mnr;
    logic [3:0] range_hit;
    logic [31:0] high_reg;
    logic [31:0] low_reg;

    assign ser = status_pkg::fault_s'(SERIOUS_IN);
    assign mnr = status_pkg::fault_s'(MINOR_IN);

    genvar g;
    generate
        for (g = 0; g < status_pkg::NUM_CH; g++) begin : g_rng
            assign range_hit[g] =
                OVER_RANGE_IN[g] & RANGE_CHECK_EN_IN[g]; // [RULE9]
        end
    endgenerate

    // Returns the code of the lowest flagged channel.
    function automatic logic [15:0] range_code(input logic [3:0] hit);
        logic [15:0] c;
        c = status_pkg::CODE_NONE;
        for (int i = status_pkg::NUM_CH - 1; i >= 0; i--) begin
            if (hit[i]) begin
                c = status_pkg::CODE_RANGE_CH1 + 16'(i);
            end
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Free-running blink divider.
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            div_reg <= 25'h0000000;
            blink_reg <= 1'b0;
        end else if (div_reg == BLINK_LAST) begin
            div_reg <= 25'h0000000;
            blink_reg <= ~blink_reg; // [RULE11]
        end else begin
            div_reg <= div_reg + 25'h0000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Severity and code selection.
    always_comb begin
        sev_next = ST_OK;
        code_next = status_pkg::CODE_NONE;
        if (ser.hw) begin // [RULE10]
            sev_next = ST_SERIOUS;
            code_next = status_pkg::CODE_SER_HW; // [RULE4]
        end else if (ser.supply) begin
            sev_next = ST_SERIOUS;
            code_next = status_pkg::CODE_SER_SUPPLY; // [RULE4]
        end else if (ser.cal) begin
            sev_next = ST_SERIOUS;
            code_next = status_pkg::CODE_SER_CAL; // [RULE4]
        end else if (mnr.supply) begin
            sev_next = ST_MINOR;
            code_next = status_pkg::CODE_MIN_SUPPLY; // [RULE5]
        end else if (mnr.hw) begin
            sev_next = ST_MINOR;
            code_next = status_pkg::CODE_MIN_HW; // [RULE5]
        end else if (mnr.cal) begin
            sev_next = ST_MINOR;
            code_next = status_pkg::CODE_MIN_CAL; // [RULE5]
        end else if (|range_hit) begin
            sev_next = ST_MINOR;
            code_next = range_code(range_hit); // [RULE6]
        end
    end

    always_comb begin
        leds_next.run = RUN_IN; // [RULE1]
        case (sev_next)
            ST_SERIOUS: leds_next.error = 1'b1; // [RULE2]
            ST_MINOR: leds_next.error = blink_reg; // [RULE2]
            default: leds_next.error = 1'b0;
        endcase
        // Device faults stop conversion display; over-range does not.
        if ((|ser) || (|mnr) || !RUN_IN || !CONVERTING_IN) begin
            leds_next.conversion = 1'b0; // [RULE4] [RULE5] [RULE3]
        end else begin
            leds_next.conversion = blink_reg; // [RULE3] [RULE6]
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            sev_reg <= ST_OK;
            code_reg <= status_pkg::CODE_NONE;
            leds_reg <= '0;
        end else begin
            sev_reg <= sev_next;
            code_reg <= code_next;
            leds_reg <= leds_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Scale points, loaded only while the host CPU is stopped.
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            high_reg <= status_pkg::SCALE_HIGH_DEFAULT; // [RULE7]
            low_reg <= status_pkg::SCALE_LOW_DEFAULT; // [RULE7]
        end else if (PARAM_LOAD_IN && !HOST_CPU_RUN_IN) begin // [RULE8]
            high_reg <= SCALE_HIGH_IN; // [RULE7]
            low_reg <= SCALE_LOW_IN; // [RULE7]
        end
    end

    assign RUN_LED_OUT = leds_reg.run;
    assign ERROR_LED_OUT = leds_reg.error;
    assign CONV_LED_OUT = leds_reg.conversion;
    assign ERROR_CODE_OUT = code_reg;
    assign SCALE_HIGH_POINT_OUT = high_reg;
    assign SCALE_LOW_POINT_OUT = low_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.
    sequence s_serious;
        |SERIOUS_IN;
    endsequence

    // Running and converting with no device fault; over-range may be set.
    sequence s_clean_run;
        RUN_IN && CONVERTING_IN && !(|SERIOUS_IN) && !(|MINOR_IN);
    endsequence

    a_run_follows: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        ##1 RUN_LED_OUT == $past(RUN_IN)) // [RULE1]
        else $error("run indicator does not follow run state");
    a_serious_steady: assert property (@(posedge MCLK_IN) // [RULE2]
        disable iff (RESET_IN) s_serious |=> ERROR_LED_OUT)
        else $error("error indicator not steady on serious fault");
    a_no_fault_dark: assert property (@(posedge MCLK_IN) // [RULE2]
        disable iff (RESET_IN) (sev_next == ST_OK) |=> !ERROR_LED_OUT)
        else $error("error indicator lit without fault");
    a_conv_stopped: assert property (@(posedge MCLK_IN) // [RULE3]
        disable iff (RESET_IN) !CONVERTING_IN |=> !CONV_LED_OUT)
        else $error("conversion indicator lit while stopped");
    a_serious_code: assert property (@(posedge MCLK_IN) // [RULE4]
        disable iff (RESET_IN) SERIOUS_IN[2] |=>
        ERROR_CODE_OUT == status_pkg::CODE_SER_HW && !CONV_LED_OUT)
        else $error("hardware failure code wrong");
    a_minor_code: assert property (@(posedge MCLK_IN) // [RULE5]
        disable iff (RESET_IN) (!(|SERIOUS_IN) && MINOR_IN[1]) |=>
        ERROR_CODE_OUT == status_pkg::CODE_MIN_SUPPLY && !CONV_LED_OUT)
        else $error("minor supply code wrong");
    a_range_ch4: assert property (@(posedge MCLK_IN) // [RULE6]
        disable iff (RESET_IN) (sev_next != ST_SERIOUS && !(|MINOR_IN)
        && range_hit == 4'h8) |=> ERROR_CODE_OUT == 16'h180B)
        else $error("channel four over-range code wrong");
    a_range_off: assert property (@(posedge MCLK_IN) // [RULE9]
        disable iff (RESET_IN) (RANGE_CHECK_EN_IN == 4'h0 && !(|SERIOUS_IN)
        && !(|MINOR_IN)) |=> ERROR_CODE_OUT == status_pkg::CODE_NONE)
        else $error("disabled range check raised a code");
    a_scale_guard: assert property (@(posedge MCLK_IN) // [RULE8]
        disable iff (RESET_IN) HOST_CPU_RUN_IN |=> $stable(high_reg))
        else $error("scale point changed while host runs");
    a_blink_period: assert property (@(posedge MCLK_IN) // [RULE11]
        disable iff (RESET_IN) $changed(blink_reg) |-> div_reg == 25'h0)
        else $error("blink toggled off the divider wrap");
    // The phase may only move on the cycle after the divider reaches BLINK_LAST.
    a_blink_hold: assert property (@(posedge MCLK_IN) // [RULE11]
        disable iff (RESET_IN) (div_reg != BLINK_LAST) |=> $stable(blink_reg))
        else $error("blink phase moved between divider wraps");
    a_minor_blink: assert property (@(posedge MCLK_IN) // [RULE2]
        disable iff (RESET_IN)
        (sev_reg == ST_MINOR) |-> ERROR_LED_OUT == $past(blink_reg))
        else $error("error indicator does not blink on minor fault");
    a_conv_blink: assert property (@(posedge MCLK_IN) // [RULE3] [RULE6]
        disable iff (RESET_IN)
        s_clean_run |=> CONV_LED_OUT == $past(blink_reg))
        else $error("conversion indicator does not blink while running");
endmodule

// *** rtl/status_pkg.sv ***
// Shared constants and carrier types for the analog input status block.
package status_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
    localparam int BLINK_W = 25;
    localparam int NUM_CH = 4;
    localparam logic [15:0] CODE_NONE = 16'h0000;
    localparam logic [15:0] CODE_SER_HW = 16'h1605;
    localparam logic [15:0] CODE_SER_SUPPLY = 16'h1607;
    localparam logic [15:0] CODE_SER_CAL = 16'h1608;
    localparam logic [15:0] CODE_MIN_SUPPLY = 16'h1801;
    localparam logic [15:0] CODE_MIN_HW = 16'h1802;
    localparam logic [15:0] CODE_MIN_CAL = 16'h1804;
    localparam logic [15:0] CODE_RANGE_CH1 = 16'h1808;
    // Scale points default to +10.0 and -10.0 in IEEE single format.
    localparam logic [31:0] SCALE_HIGH_DEFAULT = 32'h41200000;
    localparam logic [31:0] SCALE_LOW_DEFAULT = 32'hC1200000;

    typedef struct packed {
        logic hw;
        logic supply;
        logic cal;
    } fault_s;

    typedef struct packed {
        logic run;
        logic error;
        logic conversion;
    } leds_s;
endpackage

// *** bench/host_cpu_model.sv ***
// Host controller model that owns the CPU run state and scale downloads.
`timescale 1ns/1ps
module host_cpu_model (
    input wire logic clk_in,
    output logic cpu_run_out,
    output logic load_out,
    output logic [31:0] high_out,
    output logic [31:0] low_out
);
    initial begin
        cpu_run_out = 1'b1;
        load_out = 1'b0;
        high_out = 32'h0;
        low_out = 32'h0;
    end

    // A download stops the CPU in the same cycle as the load strobe; stop low commands a refused load.
    task automatic download(input logic stop, input logic [31:0] hi,
                            input logic [31:0] lo);
        @(posedge clk_in);
        cpu_run_out <= !stop;
        high_out <= hi;
        low_out <= lo;
        load_out <= 1'b1;
        @(posedge clk_in);
        load_out <= 1'b0;
        high_out <= ~hi;
        low_out <= ~lo;
        cpu_run_out <= 1'b1;
    endtask
endmodule

// *** bench/adc_status_bench.sv ***
// Self-checking bench for the analog input status block.
`timescale 1ns/1ps
module adc_status_bench;
    logic clk, rst, run, conv, cpu_run, load, rl, el, cl;
    logic [2:0] ser, mnr;
    logic [3:0] ovr, ren;
    logic [31:0] hi, lo, hi_q, lo_q;
    logic [15:0] code;
    logic [15:0] ser_codes [3] = '{16'h1605, 16'h1607, 16'h1608};
    logic [15:0] mnr_codes [3] = '{16'h1801, 16'h1802, 16'h1804};
    logic [2:0] mnr_bits [3] = '{3'h2, 3'h4, 3'h1};
    int bad_count = 0;
    int samples_checked = 0;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    host_cpu_model i_host (.clk_in(clk), .cpu_run_out(cpu_run),
        .load_out(load), .high_out(hi), .low_out(lo));
    adc_status i_dut (.MCLK_IN(clk), .RESET_IN(rst), .RUN_IN(run),
        .CONVERTING_IN(conv), .SERIOUS_IN(ser), .MINOR_IN(mnr),
        .OVER_RANGE_IN(ovr), .RANGE_CHECK_EN_IN(ren),
        .HOST_CPU_RUN_IN(cpu_run), .PARAM_LOAD_IN(load),
        .SCALE_HIGH_IN(hi), .SCALE_LOW_IN(lo), .RUN_LED_OUT(rl),
        .ERROR_LED_OUT(el), .CONV_LED_OUT(cl), .ERROR_CODE_OUT(code),
        .SCALE_HIGH_POINT_OUT(hi_q), .SCALE_LOW_POINT_OUT(lo_q));

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checked %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic drive(input logic r, c, input logic [2:0] s, m,
                         input logic [3:0] o, e);
        @(posedge clk);
        {run, conv, ser, mnr, ovr, ren} <= {r, c, s, m, o, e};
        @(posedge clk);
        #1;
    endtask

    task automatic chk_word(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    // Blink phase stays 0 for the whole run, so blinking reads as dark.
    task automatic chk_leds(input status_pkg::leds_s exp);
        samples_checked++;
        if ({rl, el, cl} !== exp) begin
            bad_count++;
            $display("[FAIL] %0t leds %b expected %b", $time, {rl, el, cl},
                     exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, run, conv, ser, mnr, ovr, ren} = {1'b1, 16'h0000};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        drive(0, 0, 0, 0, 0, 4'hF);
        chk_leds(3'b000);
        chk_word(code, 0);
        chk_word(hi_q, status_pkg::SCALE_HIGH_DEFAULT);
        chk_word(lo_q, status_pkg::SCALE_LOW_DEFAULT);
        drive(1, 1, 0, 0, 0, 4'hF);
        chk_leds(3'b100);
        for (int i = 0; i < 3; i++) begin
            drive(1, 1, 3'h4 >> i, 0, 0, 4'hF);
            chk_word(code, ser_codes[i]);
            chk_leds(3'b110);
            drive(1, 1, 0, mnr_bits[i], 0, 4'hF);
            chk_word(code, mnr_codes[i]);
            chk_leds(3'b100);
        end
        drive(1, 1, 3'h1, 3'h7, 0, 4'hF);
        chk_word(code, 16'h1608);
        chk_leds(3'b110);
        for (int i = 0; i < 4; i++) begin
            drive(1, 1, 0, 0, 4'hF << i, 4'hF);
            chk_word(code, 16'h1808 + 16'(i));
            chk_leds(3'b100);
        end
        drive(0, 0, 0, 0, 4'h1, 4'hF);
        chk_word(code, 16'h1808);
        chk_leds(3'b000);
        drive(1, 1, 0, 0, 4'hF, 4'h0);
        chk_word(code, 0);
        drive(1, 1, 0, 0, 4'hF, 4'hE);
        chk_word(code, 16'h1809);
        i_host.download(0, 32'h40A00000, 32'hC0A00000);
        #1;
        chk_word(hi_q, status_pkg::SCALE_HIGH_DEFAULT);
        i_host.download(1, 32'h40A00000, 32'hC0A00000);
        #1;
        chk_word(hi_q, 32'h40A00000);
        chk_word(lo_q, 32'hC0A00000);
        print_verdict();
    end

    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
endmodule
